// [design/otp_integrity_pkg.sv]
// Constants and types shared by the OTP shadow integrity checker
package otp_integrity_pkg;

  // Check code shape
  localparam int          CODE_W    = 3;
  localparam logic [2:0]  CODE_SEED = 3'h7;
  localparam logic [2:0]  CODE_POLY = 3'h3;

  // Shadow array shape, in 8-bit registers
  localparam int          SHADOW_W     = 8;
  localparam int          FACT_REG_CNT = 5;
  localparam int          USER_REG_CNT = 8;

  // Register bus
  localparam int          ADDR_W  = 8;
  localparam int          DATA_W  = 32;
  localparam logic [7:0]  STATUS_CHECK_OFS = 8'h0C;
  localparam logic [7:0]  IRQ_STATUS_OFS   = 8'h10;
  localparam logic [7:0]  IRQ_CLEAR_OFS    = 8'h14;
  localparam logic [7:0]  IRQ_ENABLE_OFS   = 8'h18;
  localparam logic [7:0]  CALC_CODE_OFS    = 8'h1C;
  localparam logic [7:0]  PASS_COUNT_OFS   = 8'h20;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // Status check register fields
  localparam int          FACT_OK_BIT = 2;
  localparam int          USER_OK_BIT = 4;

  // Event bits in the interrupt registers
  localparam int          EV_W        = 3;
  localparam int          EV_FACT_BIT = 0;
  localparam int          EV_USER_BIT = 1;
  localparam int          EV_PROG_BIT = 2;

  // Values after reset
  localparam logic [2:0]  EV_RST      = 3'h0;
  localparam logic [15:0] PASS_RST    = 16'h0000;
  localparam logic        FLAG_OK_RST = 1'b1;

  // Programming sequence for the user code
  typedef enum logic [1:0] {
    PROG_IDLE,
    PROG_WAIT_PASS,
    PROG_WRITE
  } prog_state_t;

endpackage : otp_integrity_pkg

// [design/serial_code_engine.sv]
// Serial 3-bit check code engine over a shadow register vector
`timescale 1ns/1ps
`default_nettype none
module serial_code_engine
  import otp_integrity_pkg::*;
#(
  parameter int N = 40
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Source vector, bit 0 of lowest register at index 0
  input  wire logic              enable,
  input  wire logic [N-1:0]      data,
  // Pass result
  output logic                   done,
  output logic [CODE_W-1:0]      result
);
  localparam int CNT_W = $clog2(N);

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [CODE_W-1:0] crc;
    logic              done;
    logic [CODE_W-1:0] result;
  } eng_t;

  eng_t st_ff;
  eng_t nxt_st;
  logic fb;
  logic [CODE_W-1:0] step;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    fb          = st_ff.crc[CODE_W-1] ^ data[st_ff.cnt];
    step        = {st_ff.crc[CODE_W-2:0], 1'b0} ^ (fb ? CODE_POLY : '0);
    if (!enable) begin
      nxt_st.cnt = '0;
      nxt_st.crc = CODE_SEED;
    end else if (st_ff.cnt == CNT_W'(N - 1)) begin
      // Last bit closes the pass, next pass reseeds at once
      nxt_st.result = step;
      nxt_st.done   = 1'b1;
      nxt_st.cnt    = '0;
      nxt_st.crc    = CODE_SEED;
    end else begin
      // LSB first, ascending register order
      nxt_st.cnt = st_ff.cnt + 1'b1;
      nxt_st.crc = step;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff.cnt    <= '0;
      st_ff.crc    <= CODE_SEED;
      st_ff.done   <= 1'b0;
      st_ff.result <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done   = st_ff.done;
  assign result = st_ff.result;

endmodule // serial_code_engine
`default_nettype wire

// [design/axil_reg_slave.sv]
// AXI4-Lite slave front end with one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave
  import otp_integrity_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Register file side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_err
);
  typedef struct packed {
    logic              aw_ok;
    logic              w_ok;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0]        strb;
    logic              awrdy;
    logic              wrdy;
    logic              bvld;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvld;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } bus_t;

  bus_t st_ff;
  bus_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    wr_en  = st_ff.aw_ok & st_ff.w_ok & ~st_ff.bvld;
    rd_en  = arvalid & st_ff.arrdy;
    if (awvalid && st_ff.awrdy) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.addr  = awaddr;
    end
    if (wvalid && st_ff.wrdy) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.data = wdata;
      nxt_st.strb = wstrb;
    end
    // Response only once both halves are in
    if (wr_en) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok  = 1'b0;
      nxt_st.bvld  = 1'b1;
      nxt_st.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_ff.bvld && bready) begin
      nxt_st.bvld = 1'b0;
    end
    if (rd_en) begin
      nxt_st.rvld  = 1'b1;
      nxt_st.rdata = rd_data;
      nxt_st.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (st_ff.rvld && rready) begin
      nxt_st.rvld = 1'b0;
    end
    // Readies held as flops so the ports come straight from registers
    nxt_st.awrdy = ~nxt_st.aw_ok & ~nxt_st.bvld & ~wr_en;
    nxt_st.wrdy  = ~nxt_st.w_ok & ~nxt_st.bvld & ~wr_en;
    nxt_st.arrdy = ~nxt_st.rvld;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awrdy;
  assign wready  = st_ff.wrdy;
  assign bvalid  = st_ff.bvld;
  assign bresp   = st_ff.bresp;
  assign arready = st_ff.arrdy;
  assign rvalid  = st_ff.rvld;
  assign rdata   = st_ff.rdata;
  assign rresp   = st_ff.rresp;
  assign wr_addr = st_ff.addr;
  assign wr_data = st_ff.data;
  assign wr_strb = st_ff.strb;
  assign rd_addr = araddr;

endmodule // axil_reg_slave
`default_nettype wire

// [design/otp_shadow_integrity_checker.sv]
// OTP shadow integrity checker: factory CRC and user code supervision
//
// Functional notes
// - Factory CRC x^3+x+1, seeded with all ones
// - Factory check only while factory lock set
// - Covers registers 0x00-0x04 plus factory configuration
// - Serial, LSB first, ascending register order
// - Pass result compared with stored factory CRC
// - Factory mismatch clears factory_array_ok_n flag
// - Uses shadow copies, never the fuses
// - User check only with user lock, independent
// - Execute command with lock writes user code
// - User code covers 0x05-0x0B and 0x0D
// - User mismatch clears user_array_ok_n flag
// - User code from shadow copies of fuses
// - Factory flag sticks at zero until reset
// - User flag sticks at zero until reset
// - Both flags in status_check_reg at 0x0C
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module otp_shadow_integrity_checker
  import otp_integrity_pkg::*;
#(
  parameter int FACT_CFG_W = 8
) (
  // Clock and reset
  input  wire logic                                CORE_CLK,
  input  wire logic                                RST,
  // Factory shadow copies, register 0x00 in the low byte
  input  wire logic [FACT_REG_CNT*SHADOW_W-1:0]    FACT_SHADOW,
  input  wire logic [FACT_CFG_W-1:0]               FACT_CFG,
  input  wire logic                                FACT_LOCK,
  input  wire logic [otp_integrity_pkg::CODE_W-1:0] FACT_CRC_STORED,
  // User shadow copies 0x05-0x0B then 0x0D, lock bit already removed
  input  wire logic [USER_REG_CNT*SHADOW_W-1:0]    USER_SHADOW,
  input  wire logic                                USER_LOCK,
  input  wire logic [otp_integrity_pkg::CODE_W-1:0] USER_CODE_STORED,
  // Programming command decoder
  input  wire logic                                PROG_EXEC,
  // Nonvolatile memory write port
  output logic                                     NVM_WR_REQ,
  output logic [otp_integrity_pkg::CODE_W-1:0]     NVM_WR_CODE,
  input  wire logic                                NVM_WR_ACK,
  // Flags and interrupt
  output logic                                     FACT_ARRAY_OK_N,
  output logic                                     USER_ARRAY_OK_N,
  output logic                                     IRQ,
  // AXI4-Lite write channels
  input  wire logic [otp_integrity_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                                AWVALID,
  output logic                                     AWREADY,
  input  wire logic [otp_integrity_pkg::DATA_W-1:0] WDATA,
  input  wire logic [3:0]                          WSTRB,
  input  wire logic                                WVALID,
  output logic                                     WREADY,
  output logic [1:0]                               BRESP,
  output logic                                     BVALID,
  input  wire logic                                BREADY,
  // AXI4-Lite read channels
  input  wire logic [otp_integrity_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                                ARVALID,
  output logic                                     ARREADY,
  output logic [otp_integrity_pkg::DATA_W-1:0]     RDATA,
  output logic [1:0]                               RRESP,
  output logic                                     RVALID,
  input  wire logic                                RREADY
);
  import otp_integrity_pkg::*;

  localparam int FACT_N = FACT_REG_CNT * SHADOW_W + FACT_CFG_W;
  localparam int USER_N = USER_REG_CNT * SHADOW_W;

  typedef struct packed {
    logic              fact_ok;
    logic              user_ok;
    logic [EV_W-1:0]   ev_status;
    logic [EV_W-1:0]   ev_enable;
    logic              irq;
    prog_state_t       prog;
    logic              nvm_req;
    logic [CODE_W-1:0] nvm_code;
    logic [CODE_W-1:0] fact_calc;
    logic [CODE_W-1:0] user_calc;
    logic [15:0]       pass_cnt;
  } chk_t;

  chk_t st_ff;
  chk_t nxt_st;

  // Engine hookup
  logic              fact_done;
  logic [CODE_W-1:0] fact_res;
  logic              user_done;
  logic [CODE_W-1:0] user_res;
  logic [FACT_N-1:0] fact_vec;

  // Register file side of the bus
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;

  // Event pulses and clear mask
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   ev_clr;
  logic              fact_mis;
  logic              user_mis;
  logic              user_check;

  // Factory lock bit is not a port of the vector, so it is excluded
  assign fact_vec = {FACT_CFG, FACT_SHADOW};

  serial_code_engine #(
    .N (FACT_N)
  ) u_fact_engine (
    .clk    (CORE_CLK),
    .rst    (RST),
    .enable (FACT_LOCK),
    .data   (fact_vec),
    .done   (fact_done),
    .result (fact_res)
  );

  serial_code_engine #(
    .N (USER_N)
  ) u_user_engine (
    .clk    (CORE_CLK),
    .rst    (RST),
    .enable (USER_LOCK),
    .data   (USER_SHADOW),
    .done   (user_done),
    .result (user_res)
  );

  axil_reg_slave u_bus (
    .clk     (CORE_CLK),
    .rst     (RST),
    .awaddr  (AWADDR),
    .awvalid (AWVALID),
    .awready (AWREADY),
    .wdata   (WDATA),
    .wstrb   (WSTRB),
    .wvalid  (WVALID),
    .wready  (WREADY),
    .bresp   (BRESP),
    .bvalid  (BVALID),
    .bready  (BREADY),
    .araddr  (ARADDR),
    .arvalid (ARVALID),
    .arready (ARREADY),
    .rdata   (RDATA),
    .rresp   (RRESP),
    .rvalid  (RVALID),
    .rready  (RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // Read decode; only the clear and enable registers take writes
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (rd_addr)
      STATUS_CHECK_OFS: begin
        rd_data[FACT_OK_BIT] = st_ff.fact_ok;
        rd_data[USER_OK_BIT] = st_ff.user_ok;
      end
      IRQ_STATUS_OFS: begin
        rd_data[EV_W-1:0] = st_ff.ev_status;
      end
      IRQ_ENABLE_OFS: begin
        rd_data[EV_W-1:0] = st_ff.ev_enable;
      end
      CALC_CODE_OFS: begin
        rd_data[CODE_W-1:0]          = st_ff.fact_calc;
        rd_data[2*CODE_W+1:CODE_W+2] = st_ff.user_calc;
      end
      PASS_COUNT_OFS: begin
        rd_data[15:0] = st_ff.pass_cnt;
      end
      IRQ_CLEAR_OFS: begin
        rd_data = '0;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  assign wr_err = (wr_addr != IRQ_CLEAR_OFS) && (wr_addr != IRQ_ENABLE_OFS);
  assign ev_clr = (wr_en && wr_strb[0] && wr_addr == IRQ_CLEAR_OFS) ?
                  wr_data[EV_W-1:0] : '0;

  // User compare is held off while a fresh code is on its way to NVM
  assign user_check = USER_LOCK && (st_ff.prog == PROG_IDLE);

  // Compare at the end of each pass, only with the check enabled
  assign fact_mis = fact_done && FACT_LOCK &&
                    (fact_res != FACT_CRC_STORED);
  assign user_mis = user_done && user_check &&
                    (user_res != USER_CODE_STORED);

  always_comb begin
    ev_set              = '0;
    ev_set[EV_FACT_BIT] = fact_mis;
    ev_set[EV_USER_BIT] = user_mis;
    ev_set[EV_PROG_BIT] = (st_ff.prog == PROG_WRITE) && NVM_WR_ACK;
  end

  always_comb begin
    nxt_st = st_ff;
    // Flags only ever fall; reset alone raises them again
    if (fact_mis) begin
      nxt_st.fact_ok = 1'b0;
    end
    if (user_mis) begin
      nxt_st.user_ok = 1'b0;
    end
    if (fact_done) begin
      nxt_st.fact_calc = fact_res;
    end
    if (user_done) begin
      nxt_st.user_calc = user_res;
    end
    if (fact_done || user_done) begin
      nxt_st.pass_cnt = st_ff.pass_cnt + 16'h0001;
    end
    // A new event beats a clear in the same cycle
    nxt_st.ev_status = (st_ff.ev_status & ~ev_clr) | ev_set;
    if (wr_en && wr_strb[0] && wr_addr == IRQ_ENABLE_OFS) begin
      nxt_st.ev_enable = wr_data[EV_W-1:0];
    end
    nxt_st.irq = |(nxt_st.ev_status & nxt_st.ev_enable);
    // Code programming takes the result of the next user engine pass to finish
    case (st_ff.prog)
      PROG_IDLE: begin
        if (PROG_EXEC && USER_LOCK) begin
          nxt_st.prog = PROG_WAIT_PASS;
        end
      end
      PROG_WAIT_PASS: begin
        if (!USER_LOCK) begin
          nxt_st.prog = PROG_IDLE;
        end else if (user_done) begin
          nxt_st.prog     = PROG_WRITE;
          nxt_st.nvm_req  = 1'b1;
          nxt_st.nvm_code = user_res;
        end
      end
      PROG_WRITE: begin
        // Request and code stand until the memory acknowledges
        if (NVM_WR_ACK) begin
          nxt_st.prog    = PROG_IDLE;
          nxt_st.nvm_req = 1'b0;
        end
      end
      default: begin
        nxt_st.prog    = PROG_IDLE;
        nxt_st.nvm_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_ff.fact_ok   <= FLAG_OK_RST;
      st_ff.user_ok   <= FLAG_OK_RST;
      st_ff.ev_status <= EV_RST;
      st_ff.ev_enable <= EV_RST;
      st_ff.irq       <= 1'b0;
      st_ff.prog      <= PROG_IDLE;
      st_ff.nvm_req   <= 1'b0;
      st_ff.nvm_code  <= '0;
      st_ff.fact_calc <= '0;
      st_ff.user_calc <= '0;
      st_ff.pass_cnt  <= PASS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign FACT_ARRAY_OK_N = st_ff.fact_ok;
  assign USER_ARRAY_OK_N = st_ff.user_ok;
  assign IRQ             = st_ff.irq;
  assign NVM_WR_REQ      = st_ff.nvm_req;
  assign NVM_WR_CODE     = st_ff.nvm_code;

endmodule // otp_shadow_integrity_checker
`default_nettype wire

// [verification/otp_integrity_asserts.sv]
// Port-level checks for the OTP shadow integrity checker
`timescale 1ns/1ps
`default_nettype none
module otp_integrity_asserts
  import otp_integrity_pkg::*;
(
  // Clock and reset
  input  wire logic                                CORE_CLK,
  input  wire logic                                RST,
  // Locks and programming
  input  wire logic                                FACT_LOCK,
  input  wire logic                                USER_LOCK,
  input  wire logic                                PROG_EXEC,
  input  wire logic                                NVM_WR_REQ,
  input  wire logic [otp_integrity_pkg::CODE_W-1:0] NVM_WR_CODE,
  input  wire logic                                NVM_WR_ACK,
  // Flags
  input  wire logic                                FACT_ARRAY_OK_N,
  input  wire logic                                USER_ARRAY_OK_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_fact_sticky: assert property (
    !FACT_ARRAY_OK_N |=> !FACT_ARRAY_OK_N)
    else $error("factory flag left zero before reset");
  chk_user_sticky: assert property (
    !USER_ARRAY_OK_N |=> !USER_ARRAY_OK_N)
    else $error("user flag left zero before reset");
  chk_fact_locked: assert property (
    $fell(FACT_ARRAY_OK_N) |-> $past(FACT_LOCK, 1))
    else $error("factory flag fell with lock open");
  chk_user_locked: assert property (
    $fell(USER_ARRAY_OK_N) |-> $past(USER_LOCK, 1))
    else $error("user flag fell with lock open");
  chk_flags_init: assert property (
    $fell(RST) |-> FACT_ARRAY_OK_N && USER_ARRAY_OK_N)
    else $error("flags not one after reset");
  chk_write_hold: assert property (
    NVM_WR_REQ && !NVM_WR_ACK |=> NVM_WR_REQ && $stable(NVM_WR_CODE))
    else $error("code write dropped before ack");
  chk_prog_answer: assert property (
    PROG_EXEC && USER_LOCK && !NVM_WR_REQ
      |-> ##[1:70] (NVM_WR_REQ || !USER_LOCK))
    else $error("no code write after execute command");
  chk_write_ends: assert property (
    NVM_WR_REQ && NVM_WR_ACK |=> !NVM_WR_REQ)
    else $error("code write held after ack");
endmodule // otp_integrity_asserts

bind otp_shadow_integrity_checker otp_integrity_asserts otp_integrity_asserts_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .FACT_LOCK(FACT_LOCK),
  .USER_LOCK(USER_LOCK), .PROG_EXEC(PROG_EXEC), .NVM_WR_REQ(NVM_WR_REQ),
  .NVM_WR_CODE(NVM_WR_CODE), .NVM_WR_ACK(NVM_WR_ACK),
  .FACT_ARRAY_OK_N(FACT_ARRAY_OK_N), .USER_ARRAY_OK_N(USER_ARRAY_OK_N));
`default_nettype wire

// [verification/otp_shadow_partner.sv]
// Far-side model: execute command decoder and NVM code store
`timescale 1ns/1ps
`default_nettype none
module otp_shadow_partner
  import otp_integrity_pkg::*;
(
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst,
  // Bench hooks
  input  wire logic                                cmd,
  input  wire logic                                slow,
  // Device side
  input  wire logic                                nvm_wr_req,
  input  wire logic [otp_integrity_pkg::CODE_W-1:0] nvm_wr_code,
  output logic                                     prog_exec,
  output logic                                     nvm_wr_ack,
  output logic [otp_integrity_pkg::CODE_W-1:0]     code_stored
);
  logic [3:0] wait_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_exec   <= 1'b0;
      // Stored code is nonvolatile, so it survives a reset
      nvm_wr_ack  <= 1'b0;
      wait_ff     <= 4'h0;
    end else begin
      // Decoded command is cmd delayed by one cycle
      prog_exec  <= cmd;
      nvm_wr_ack <= 1'b0;
      if (nvm_wr_req && !nvm_wr_ack) begin
        // Slow mode keeps the device waiting on a held request
        if (wait_ff == (slow ? 4'h6 : 4'h0)) begin
          nvm_wr_ack  <= 1'b1;
          code_stored <= nvm_wr_code;
          wait_ff     <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
    end
  end
endmodule // otp_shadow_partner
`default_nettype wire

// [verification/otp_shadow_integrity_checker_bench.sv]
// Self-checking bench for the OTP shadow integrity checker
`timescale 1ns/1ps
`default_nettype none
module otp_shadow_integrity_checker_bench;
  import otp_integrity_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [39:0] fsh;
  logic [7:0]  fcfg, awaddr, araddr;
  logic [63:0] ush;
  logic [2:0]  fcrc, ucode, wcode;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        flock, ulock, cmd, slow, prog, wreq, wack, fok, uok, irq;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  int          error_cnt, check_count, k;

  always #4 clk = ~clk;

  otp_shadow_integrity_checker otp_shadow_integrity_checker_i (
    .CORE_CLK(clk), .RST(rst), .FACT_SHADOW(fsh), .FACT_CFG(fcfg),
    .FACT_LOCK(flock), .FACT_CRC_STORED(fcrc), .USER_SHADOW(ush),
    .USER_LOCK(ulock), .USER_CODE_STORED(ucode), .PROG_EXEC(prog),
    .NVM_WR_REQ(wreq), .NVM_WR_CODE(wcode), .NVM_WR_ACK(wack),
    .FACT_ARRAY_OK_N(fok), .USER_ARRAY_OK_N(uok), .IRQ(irq),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  otp_shadow_partner otp_shadow_partner_i (
    .clk(clk), .rst(rst), .cmd(cmd), .slow(slow), .nvm_wr_req(wreq),
    .nvm_wr_code(wcode), .prog_exec(prog), .nvm_wr_ack(wack),
    .code_stored(ucode));

  // Serial CRC, index 0 first, all-ones seed, x^3+x+1
  function automatic logic [2:0] crc3(input logic [63:0] v, input int n);
    logic [2:0] c;
    c = 3'h7;
    for (int i = 0; i < n; i++) begin
      c = {c[1:0], 1'b0} ^ ((c[2] ^ v[i]) ? 3'h3 : 3'h0);
    end
    return c;
  endfunction

  task cmp_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cmp_flag(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Request stays up until its own ready is sampled
  task axi_wr(input logic [7:0] a, input logic [31:0] v,
              output logic [1:0] s);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    s = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] v,
              output logic [1:0] s);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask

  task rd_cmp(input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] es);
    axi_rd(a, d, r);
    cmp_word(d, e);
    cmp_word({30'h0, r}, {30'h0, es});
  endtask

  task wr_cmp(input logic [7:0] a, input logic [31:0] v,
              input logic [1:0] es);
    axi_wr(a, v, r);
    cmp_word({30'h0, r}, {30'h0, es});
  endtask

  task close_out;
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run is under two thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    close_out;
  end

  initial begin
    {fsh, fcfg, ush, flock, ulock, cmd, slow, fcrc} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    error_cnt = 0;
    check_count = 0;
    k = $urandom(96);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_cmp(STATUS_CHECK_OFS, 32'h0000_0014, RESP_OKAY);
    rd_cmp(8'h40, 32'h0000_0000, RESP_SLVERR);
    wr_cmp(STATUS_CHECK_OFS, 32'h0000_0001, RESP_SLVERR);
    rd_cmp(IRQ_ENABLE_OFS, 32'h0000_0000, RESP_OKAY);
    // Locks open with a wrong stored CRC: nothing is judged
    @(posedge clk);
    fsh <= 40'({$urandom(), $urandom()});
    ush <= {$urandom(), $urandom()};
    @(posedge clk);
    fcrc <= ~crc3(64'({fcfg, fsh}), 48);
    repeat (150) @(posedge clk);
    cmp_flag(fok, 1'b1);
    cmp_flag(uok, 1'b1);
    // Zeros, ones, then random data; lock dropped while data change
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      flock <= 1'b0;
      fsh <= (i == 0) ? '0 : (i == 1) ? '1 : 40'({$urandom(), $urandom()});
      fcfg <= (i == 0) ? '0 : (i == 1) ? '1 : 8'($urandom());
      @(posedge clk);
      fcrc <= crc3(64'({fcfg, fsh}), 48);
      flock <= 1'b1;
      repeat (150) @(posedge clk);
      cmp_flag(fok, 1'b1);
      axi_rd(CALC_CODE_OFS, d, r);
      cmp_word({29'h0, d[2:0]}, {29'h0, fcrc});
    end
    // Execute command with user lock set; slow NVM acknowledge
    @(posedge clk);
    ulock <= 1'b1;
    cmd <= 1'b1;
    slow <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    k = 0;
    while (wreq !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    cmp_word({29'h0, wcode}, {29'h0, crc3(ush, 64)});
    repeat (150) @(posedge clk);
    cmp_flag(uok, 1'b1);
    axi_rd(CALC_CODE_OFS, d, r);
    cmp_word({29'h0, d[7:5]}, {29'h0, crc3(ush, 64)});
    rd_cmp(IRQ_STATUS_OFS, 32'h0000_0004, RESP_OKAY);
    // Factory mismatch with interrupt enabled, then repaired
    wr_cmp(IRQ_CLEAR_OFS, 32'h0000_0007, RESP_OKAY);
    wr_cmp(IRQ_ENABLE_OFS, 32'h0000_0003, RESP_OKAY);
    rd_cmp(IRQ_ENABLE_OFS, 32'h0000_0003, RESP_OKAY);
    k = $urandom_range(47, 0);
    @(posedge clk);
    {fcfg, fsh} <= {fcfg, fsh} ^ (48'h1 << k);
    repeat (110) @(posedge clk);
    cmp_flag(fok, 1'b0);
    cmp_flag(irq, 1'b1);
    rd_cmp(STATUS_CHECK_OFS, 32'h0000_0010, RESP_OKAY);
    @(posedge clk);
    {fcfg, fsh} <= {fcfg, fsh} ^ (48'h1 << k);
    repeat (110) @(posedge clk);
    wr_cmp(IRQ_CLEAR_OFS, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp_flag(irq, 1'b0);
    cmp_flag(fok, 1'b0);
    // User mismatch with its interrupt masked
    wr_cmp(IRQ_ENABLE_OFS, 32'h0000_0001, RESP_OKAY);
    k = $urandom_range(63, 0);
    @(posedge clk);
    ush <= ush ^ (64'h1 << k);
    repeat (140) @(posedge clk);
    cmp_flag(uok, 1'b0);
    cmp_flag(irq, 1'b0);
    rd_cmp(IRQ_STATUS_OFS, 32'h0000_0002, RESP_OKAY);
    @(posedge clk);
    ush <= ush ^ (64'h1 << k);
    repeat (140) @(posedge clk);
    rd_cmp(STATUS_CHECK_OFS, 32'h0000_0000, RESP_OKAY);
    // Only a reset brings the flags back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp_flag(fok, 1'b1);
    cmp_flag(uok, 1'b1);
    rd_cmp(PASS_COUNT_OFS, 32'h0000_0000, RESP_OKAY);
    // Stored code kept over reset, so checks resume clean
    repeat (140) @(posedge clk);
    cmp_flag(uok, 1'b1);
    cmp_flag(fok, 1'b1);
    close_out;
  end
endmodule // otp_shadow_integrity_checker_bench
`default_nettype wire
